/* core/card_slot_pkg.sv */
package card_slot_pkg;

    // Register bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Register offsets on the local port
    localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'hE0;
    localparam logic [ADDR_W-1:0] GEN_CTRL_OFFSET = 8'hE2;

    // Status register field positions
    localparam int READY_OR_REQUEST_BIT = 7;
    localparam int WRITE_PROTECT_BIT = 6;
    localparam int VOLTAGE_SENSE_HI_BIT = 5;
    localparam int VOLTAGE_SENSE_LO_BIT = 4;
    localparam int CARD_DETECT_HI_BIT = 3;
    localparam int CARD_DETECT_LO_BIT = 2;
    localparam int BATTERY_DETECT_HI_BIT = 1;
    localparam int BATTERY_DETECT_LO_BIT = 0;

    // General control register field positions
    localparam int DRIVE_ENABLE_BIT = 7;
    localparam int CARD_RESET_BIT = 6;
    localparam int CARD_TYPE_SELECT_BIT = 5;
    localparam int GEN_CTRL_RESERVED_BIT = 4;
    localparam int MAP_MODE_BIT = 3;
    localparam int ADDR25_BIT = 2;
    localparam int ADDR24_BIT = 1;
    localparam int SPACE_SELECT_BIT = 0;

    // Reset and fill values, and the control readback mask
    localparam logic [DATA_W-1:0] GEN_CTRL_RESET = 8'h00;
    localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;
    localparam logic [DATA_W-1:0] GEN_CTRL_WRITABLE = 8'hEF;

    // Card type encoding
    typedef enum logic {
        CARD_MEMORY = 1'b0,
        CARD_IO = 1'b1
    } card_kind_type;

    // Raw levels from the card socket
    typedef struct packed {
        logic ready_busy;
        logic int_request;
        logic write_protect;
        logic voltage_sense_2;
        logic voltage_sense_1;
        logic card_detect_2;
        logic card_detect_1;
        logic battery_voltage_2;
        logic battery_voltage_1;
        logic speaker;
        logic status_change;
    } card_pins_type;

    // Register port request from software
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_type;

    // Controls driven out of the general control register
    typedef struct packed {
        logic drive_enable;
        logic card_reset;
        logic card_type_select;
        logic map_mode;
        logic addr25;
        logic addr24;
        logic space_select;
    } slot_ctrl_type;

endpackage

/* core/card_slot_status_register.sv */
`timescale 1ns/1ps
// Overview of operation
// - Status register is eight bits, read only; writes leave every bit unchanged.
// - No fixed reset value; bits other than I/O bit 6 follow card pin levels, two edges late through the synchroniser.
// - Memory card: bit 7 shows the ready/busy pin.
// - I/O card: bit 7 shows the interrupt request pin.
// - Memory card: bit 6 shows the write protect pin.
// - I/O card: bit 6 always reads zero.
// - Bits 5 and 4 show voltage sense 2 and 1 for both types.
// - Bits 3 and 2 show card detect 2 and 1 for both types.
// - Memory card: bits 1 and 0 show battery voltage detect 2 and 1.
// - I/O card: bits 1 and 0 show speaker and status change pins.
// - Card type comes from control register bit 5: zero memory, one I/O.
module card_slot_status_register
    import card_slot_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire reg_req_type reg_req,
    output logic [DATA_W-1:0] reg_rdata,
    input wire card_pins_type card_pins,
    output slot_ctrl_type slot_ctrl
);

    // Synchroniser stages
    card_pins_type pins_meta_r;
    card_pins_type pins_sync_r;

    // Control register fields, one flop per field
    logic drive_enable_r;
    logic drive_enable_nxt;
    logic card_reset_r;
    logic card_reset_nxt;
    logic card_type_select_r;
    logic card_type_select_nxt;
    logic map_mode_r;
    logic map_mode_nxt;
    logic addr25_r;
    logic addr25_nxt;
    logic addr24_r;
    logic addr24_nxt;
    logic space_select_r;
    logic space_select_nxt;

    // Decoded strobes of the register port
    logic ctrl_write;
    logic ctrl_read;
    logic status_read;

    // Assembled views
    slot_ctrl_type ctrl_fields;
    logic [DATA_W-1:0] gen_ctrl_view;
    logic [DATA_W-1:0] status_view;
    logic [DATA_W-1:0] rdata_nxt;
    card_kind_type card_kind;

    // Status register address match
    function automatic logic is_status_addr(input logic [ADDR_W-1:0] a);
        logic hit;
        if (a == STATUS_OFFSET) begin
            hit = 1'b1;
        end else begin
            hit = 1'b0;
        end
        return hit;
    endfunction

    // Control register address match; shared by the write and read paths
    function automatic logic is_ctrl_addr(input logic [ADDR_W-1:0] a);
        logic hit;
        if (a == GEN_CTRL_OFFSET) begin
            hit = 1'b1;
        end else begin
            hit = 1'b0;
        end
        return hit;
    endfunction

    // Next value of one control field; holds unless its register is written
    function automatic logic field_next(
        input logic cur,
        input logic wr,
        input logic d
    );
        logic n;
        n = cur;
        if (wr) begin
            n = d;
        end
        return n;
    endfunction

    // Card type from the select bit; zero is memory, one is I/O
    function automatic card_kind_type kind_from_bit(input logic b);
        card_kind_type k;
        if (b) begin
            k = CARD_IO;
        end else begin
            k = CARD_MEMORY;
        end
        return k;
    endfunction

    // Bit 7: ready/busy for memory cards, interrupt request for I/O cards
    function automatic logic ready_level(
        input card_pins_type p,
        input card_kind_type kind
    );
        logic v;
        case (kind)
            CARD_MEMORY: begin
                v = p.ready_busy;
            end
            default: begin
                v = p.int_request;
            end
        endcase
        return v;
    endfunction

    // Bit 6: write protect for memory cards, forced low for I/O cards
    function automatic logic protect_level(
        input card_pins_type p,
        input card_kind_type kind
    );
        logic v;
        case (kind)
            CARD_MEMORY: begin
                v = p.write_protect;
            end
            default: begin
                v = 1'b0;
            end
        endcase
        return v;
    endfunction

    // Bit 1: battery detect 2 for memory cards, speaker for I/O cards
    function automatic logic battery_hi_level(
        input card_pins_type p,
        input card_kind_type kind
    );
        logic v;
        case (kind)
            CARD_MEMORY: begin
                v = p.battery_voltage_2;
            end
            default: begin
                v = p.speaker;
            end
        endcase
        return v;
    endfunction

    // Bit 0: battery detect 1 for memory cards, status change for I/O cards
    function automatic logic battery_lo_level(
        input card_pins_type p,
        input card_kind_type kind
    );
        logic v;
        case (kind)
            CARD_MEMORY: begin
                v = p.battery_voltage_1;
            end
            default: begin
                v = p.status_change;
            end
        endcase
        return v;
    endfunction

    // Status byte from synchronised pins and the card type
    function automatic logic [DATA_W-1:0] status_byte(
        input card_pins_type p,
        input card_kind_type kind
    );
        logic [DATA_W-1:0] s;
        s = READ_IDLE;
        s[READY_OR_REQUEST_BIT] = ready_level(p, kind);
        s[WRITE_PROTECT_BIT] = protect_level(p, kind);
        s[VOLTAGE_SENSE_HI_BIT] = p.voltage_sense_2;
        s[VOLTAGE_SENSE_LO_BIT] = p.voltage_sense_1;
        s[CARD_DETECT_HI_BIT] = p.card_detect_2;
        s[CARD_DETECT_LO_BIT] = p.card_detect_1;
        s[BATTERY_DETECT_HI_BIT] = battery_hi_level(p, kind);
        s[BATTERY_DETECT_LO_BIT] = battery_lo_level(p, kind);
        return s;
    endfunction

    // Control readback; the reserved bit always reads zero
    function automatic logic [DATA_W-1:0] ctrl_byte(input slot_ctrl_type c);
        logic [DATA_W-1:0] v;
        v = READ_IDLE;
        v[DRIVE_ENABLE_BIT] = c.drive_enable;
        v[CARD_RESET_BIT] = c.card_reset;
        v[CARD_TYPE_SELECT_BIT] = c.card_type_select;
        v[MAP_MODE_BIT] = c.map_mode;
        v[ADDR25_BIT] = c.addr25;
        v[ADDR24_BIT] = c.addr24;
        v[SPACE_SELECT_BIT] = c.space_select;
        return v & GEN_CTRL_WRITABLE;
    endfunction

    // First synchroniser stage; the card drives its pins with no relation to our clock
    // No reset: the stages keep sampling through reset, so the view is live at release
    always_ff @(posedge sys_clk) begin
        pins_meta_r <= card_pins;
    end

    // Second stage; nothing else reads the first stage
    always_ff @(posedge sys_clk) begin
        pins_sync_r <= pins_meta_r;
    end

    // Card type from the control field
    assign card_kind = kind_from_bit(card_type_select_r);

    // Live view with no storage of its own, so no fixed reset value
    // Limitation: a read shows the pins as they stood two edges before it
    assign status_view = status_byte(pins_sync_r, card_kind);

    // Strobe decode; a write to the status address matches nothing and is dropped
    assign ctrl_write = reg_req.wr && is_ctrl_addr(reg_req.addr);
    assign ctrl_read = reg_req.rd && is_ctrl_addr(reg_req.addr);
    assign status_read = reg_req.rd && is_status_addr(reg_req.addr);

    // Control fields; the reserved bit has no flop and reads zero
    // Drive enable field
    // Exported only; the slot buffer control follows it
    assign drive_enable_nxt = field_next(drive_enable_r, ctrl_write,
        reg_req.wdata[DRIVE_ENABLE_BIT]);
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            drive_enable_r <= GEN_CTRL_RESET[DRIVE_ENABLE_BIT];
        end else begin
            drive_enable_r <= drive_enable_nxt;
        end
    end

    // Card reset field
    // Exported only; level for the card's reset line
    assign card_reset_nxt = field_next(card_reset_r, ctrl_write,
        reg_req.wdata[CARD_RESET_BIT]);
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            card_reset_r <= GEN_CTRL_RESET[CARD_RESET_BIT];
        end else begin
            card_reset_r <= card_reset_nxt;
        end
    end

    // Card type select field
    // Also steers status bits 7, 6, 1 and 0 from the next edge
    assign card_type_select_nxt = field_next(card_type_select_r, ctrl_write,
        reg_req.wdata[CARD_TYPE_SELECT_BIT]);
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            card_type_select_r <= GEN_CTRL_RESET[CARD_TYPE_SELECT_BIT];
        end else begin
            card_type_select_r <= card_type_select_nxt;
        end
    end

    // Map mode field
    // Exported only; picks the card address map
    assign map_mode_nxt = field_next(map_mode_r, ctrl_write,
        reg_req.wdata[MAP_MODE_BIT]);
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            map_mode_r <= GEN_CTRL_RESET[MAP_MODE_BIT];
        end else begin
            map_mode_r <= map_mode_nxt;
        end
    end

    // Upper card address field, bit 25
    // Exported only; meaningful for common memory access
    assign addr25_nxt = field_next(addr25_r, ctrl_write,
        reg_req.wdata[ADDR25_BIT]);
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            addr25_r <= GEN_CTRL_RESET[ADDR25_BIT];
        end else begin
            addr25_r <= addr25_nxt;
        end
    end

    // Upper card address field, bit 24
    // Exported only; used in the smaller map mode
    assign addr24_nxt = field_next(addr24_r, ctrl_write,
        reg_req.wdata[ADDR24_BIT]);
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            addr24_r <= GEN_CTRL_RESET[ADDR24_BIT];
        end else begin
            addr24_r <= addr24_nxt;
        end
    end

    // Space select field
    // Exported only; attribute or common memory
    assign space_select_nxt = field_next(space_select_r, ctrl_write,
        reg_req.wdata[SPACE_SELECT_BIT]);
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            space_select_r <= GEN_CTRL_RESET[SPACE_SELECT_BIT];
        end else begin
            space_select_r <= space_select_nxt;
        end
    end

    // Field flops gathered for export and readback
    assign ctrl_fields.drive_enable = drive_enable_r;
    assign ctrl_fields.card_reset = card_reset_r;
    assign ctrl_fields.card_type_select = card_type_select_r;
    assign ctrl_fields.map_mode = map_mode_r;
    assign ctrl_fields.addr25 = addr25_r;
    assign ctrl_fields.addr24 = addr24_r;
    assign ctrl_fields.space_select = space_select_r;

    // Control outputs are plain register levels
    assign slot_ctrl = ctrl_fields;

    // Control readback image
    assign gen_ctrl_view = ctrl_byte(ctrl_fields);

    // Read mux; unmapped and idle cycles return zero
    always_comb begin
        rdata_nxt = READ_IDLE;
        if (status_read) begin
            rdata_nxt = status_view;
        end else if (ctrl_read) begin
            rdata_nxt = gen_ctrl_view;
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= READ_IDLE;
        end else begin
            reg_rdata <= rdata_nxt;
        end
    end

endmodule

/* verif/card_slot_asserts.sv */
`timescale 1ns/1ps
module card_slot_asserts
    import card_slot_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire reg_req_type reg_req,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire card_pins_type card_pins,
    input wire slot_ctrl_type slot_ctrl
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Expected view; p[7:4] are the sense and detect pins
    function automatic logic [7:0] f(card_pins_type p, logic io);
        return {io ? p.int_request : p.ready_busy, !io && p.write_protect, p[7:4],
            io ? p[1:0] : p[3:2]};
    endfunction
    // Status read well clear of reset, so the two sync flops hold real pins
    sequence rd3;
        !rst [*3] ##0 (reg_req.rd && reg_req.addr == STATUS_OFFSET);
    endsequence
    property view_p(logic [7:0] m);
        rd3 |=> (reg_rdata & m) ==
            (f($past(card_pins, 3), $past(slot_ctrl.card_type_select)) & m);
    endproperty
    AST_BIT7: assert property (view_p(8'h80)) else $error("bit 7");
    AST_BIT6: assert property (view_p(8'h40)) else $error("bit 6");
    AST_SENSE: assert property (view_p(8'h30)) else $error("sense");
    AST_DETECT: assert property (view_p(8'h0C)) else $error("detect");
    AST_LOW: assert property (view_p(8'h03)) else $error("bits 1:0");
    AST_TYPE:
    assert property (reg_req.wr && reg_req.addr == GEN_CTRL_OFFSET |=>
        slot_ctrl.card_type_select == $past(reg_req.wdata[5])) else $error("type bit");
    AST_RO:
    assert property (reg_req.wr && reg_req.addr == STATUS_OFFSET |=> $stable(slot_ctrl))
        else $error("status write");
    AST_IDLE: assert property (!$past(reg_req.rd) |-> reg_rdata == READ_IDLE)
        else $error("stray read data");
endmodule
bind card_slot_status_register card_slot_asserts u_chk (.sys_clk(sys_clk), .rst(rst),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .card_pins(card_pins), .slot_ctrl(slot_ctrl));

/* verif/card_model.sv */
`timescale 1ns/1ps
module card_model
    import card_slot_pkg::*;
(
    input wire logic sys_clk,
    input wire logic [10:0] plan,
    output card_pins_type pins
);
    // Pins move one edge after the plan, unrelated to any read
    always_ff @(posedge sys_clk) begin
        pins <= plan;
    end
endmodule

/* verif/tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
    $display("unexpected %s exp %h got %h", n, e, g); end end
module tb
    import card_slot_pkg::*;
;
    logic sys_clk = 0;
    logic rst = 1;
    reg_req_type req = '0;
    logic [7:0] rdata;
    logic [10:0] plan = '0;
    card_pins_type pins;
    slot_ctrl_type ctrl;
    int errors = 0;
    int total_checks = 0;
    card_slot_status_register u_dut (.sys_clk(sys_clk), .rst(rst), .reg_req(req),
        .reg_rdata(rdata), .card_pins(pins), .slot_ctrl(ctrl));
    card_model u_card (.sys_clk(sys_clk), .plan(plan), .pins(pins));
    // 100 ns clock
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    function automatic logic [7:0] view(logic [10:0] p, logic io);
        return {io ? p[9] : p[10], !io & p[8], p[7:4], io ? p[1:0] : p[3:2]};
    endfunction
    // One strobe cycle; read data only valid in the cycle after
    task automatic access(input logic wr, input logic [7:0] a, d);
        @(posedge sys_clk);
        req <= '{addr: a, wdata: d, wr: wr, rd: !wr};
        @(posedge sys_clk);
        req <= '0;
        @(negedge sys_clk);
    endtask
    task automatic rd_chk(input logic [7:0] a, e, input string n);
        access(0, a, 8'h00);
        `CHK(n, e, rdata)
    endtask
    // Walk a one over every pin, then all high, in one card type
    task automatic scan(input logic io);
        access(1, GEN_CTRL_OFFSET, {2'b00, io, 5'h00});
        rd_chk(GEN_CTRL_OFFSET, {2'b00, io, 5'h00}, "type");
        for (int i = 0; i < 12; i++) begin
            @(posedge sys_clk);
            plan <= (i == 11) ? 11'h7FF : 11'h001 << i;
            repeat (3) @(posedge sys_clk);
            rd_chk(STATUS_OFFSET, view(plan, io), "status");
        end
    endtask
    // Writes to status must not stick; bit 4 of control is dead
    task automatic read_only();
        access(1, STATUS_OFFSET, 8'hFF);
        rd_chk(STATUS_OFFSET, view(plan, 1'b1), "ro");
        access(1, GEN_CTRL_OFFSET, 8'hFF);
        `CHK("slot ctrl", 7'h7F, ctrl)
        rd_chk(GEN_CTRL_OFFSET, GEN_CTRL_WRITABLE, "gctl");
        rd_chk(8'h10, READ_IDLE, "unmapped");
    endtask
    // Software decode of the battery pair: 11 good, 01 warning, anything else dead
    function automatic logic [1:0] battery_state(logic [1:0] b);
        return (b == 2'h3) ? 2'h2 : ((b == 2'h1) ? 2'h1 : 2'h0);
    endfunction
    // Memory view: drive one battery pair, read it and decode it as software would
    task automatic battery(input logic [1:0] b, input logic [1:0] e);
        @(posedge sys_clk);
        plan <= {7'h00, b, 2'b00};
        repeat (3) @(posedge sys_clk);
        access(0, STATUS_OFFSET, 8'h00);
        `CHK("battery", e, battery_state(rdata[1:0]))
    endtask
    // Mid-run reset with the pins held: the view must not drop to a fixed value
    task automatic reset_live();
        @(posedge sys_clk);
        plan <= 11'h5A5;
        repeat (3) @(posedge sys_clk);
        rst <= 1;
        repeat (2) @(posedge sys_clk);
        rst <= 0;
        rd_chk(STATUS_OFFSET, view(11'h5A5, 1'b0), "live after reset");
        rd_chk(GEN_CTRL_OFFSET, GEN_CTRL_RESET, "ctrl after reset");
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Main sequence: memory view, then I/O view
    initial begin
        repeat (4) @(posedge sys_clk);
        rst <= 0;
        scan(1'b0);
        scan(1'b1);
        read_only();
        access(1, GEN_CTRL_OFFSET, 8'h00);
        battery(2'h3, 2'h2);
        battery(2'h1, 2'h1);
        battery(2'h2, 2'h0);
        battery(2'h0, 2'h0);
        reset_live();
        tally_and_finish();
    end
    // Watchdog, far beyond the few hundred cycles needed
    initial begin
        #200000;
        errors++;
        tally_and_finish();
    end
endmodule
